// File: quad_tx_pkg.sv
// shared constants, types and register map of the quad transmit control block
package quad_tx_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] ENABLE_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] RATE_OFFSET = 8'h0c;

	// control register fields
	localparam int CTRL_QUAD_BIT = 0;
	localparam int CTRL_LOOP_BIT = 1;
	localparam int CTRL_MULT_BIT = 2;
	localparam int CTRL_SPEED_LSB = 3;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// enable register fields
	localparam int ENABLE_BUS_LSB = 0;
	localparam int ENABLE_OE_BIT = 8;
	localparam int ENABLE_BIST_BIT = 9;
	localparam int ENABLE_RX_BIT = 10;
	localparam logic [10:0] ENABLE_RESET = 11'h0ff;

	// status register fields
	localparam int STATUS_DRV_LSB = 0;
	localparam int STATUS_LOWPWR_LSB = 8;
	localparam int STATUS_TXBIST_LSB = 12;
	localparam int STATUS_RXBIST_LSB = 16;
	localparam int STATUS_RXEN_LSB = 20;
	localparam int STATUS_SYNC_LSB = 24;

	// rate register fields
	localparam int RATE_REFMIN_LSB = 0;
	localparam int RATE_REFMAX_LSB = 8;
	localparam int RATE_MULT_LSB = 16;
	localparam int RATE_RANGE_LSB = 21;

	// latch reset values
	localparam logic [7:0] OE_LATCH_RESET = 8'hff;
	localparam logic [7:0] BIST_LATCH_RESET = 8'hff;
	localparam logic [7:0] RX_LATCH_RESET = 8'hff;

	// ****************************************
	// timing and rate figures
	// ****************************************
	localparam logic [4:0] SYNC_LEN = 5'h10;
	localparam logic [3:0] SYNC_LAST = 4'(SYNC_LEN - 5'h01);
	localparam logic [4:0] MULT_FULL = 5'h0a;
	localparam logic [4:0] MULT_HALF = 5'h14;
	localparam logic [10:0] BAUD_LOW_MIN = 11'd200;
	localparam logic [10:0] BAUD_LOW_MAX = 11'd400;
	localparam logic [10:0] BAUD_MID_MIN = 11'd400;
	localparam logic [10:0] BAUD_MID_MAX = 11'd800;
	localparam logic [10:0] BAUD_HIGH_MIN = 11'd800;
	localparam logic [10:0] BAUD_HIGH_MAX = 11'd1500;
	localparam logic [7:0] REF_LOW_MIN = 8'd20;
	localparam logic [7:0] REF_LOW_MAX = 8'd40;
	localparam logic [7:0] REF_MID_MIN = 8'd40;
	localparam logic [7:0] REF_MID_MAX = 8'd80;
	localparam logic [7:0] REF_HIGH_MIN = 8'd80;
	localparam logic [7:0] REF_HIGH_MAX = 8'd150;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {CHAR_DATA, CHAR_FILL, CHAR_SPECIAL, CHAR_SYNC} char_kind_t;
	typedef enum logic [1:0] {SPEED_LOW, SPEED_MID, SPEED_HIGH} speed_range_t;

	typedef struct packed {
		char_kind_t [3:0] kind;
		logic [3:0][7:0] data;
		logic [3:0] syncActive;
		logic [3:0][3:0] syncIndex;
		logic [3:0] bistOn;
	} tx_out_t;

	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] forceOne;
		logic [7:0] minPower;
		logic [3:0] chanLowPower;
	} driver_ctl_t;

	typedef struct packed {
		logic [3:0] txBist;
		logic [3:0] rxBist;
		logic [3:0] rxEnable;
	} chan_enable_t;

	typedef struct packed {
		logic [4:0] bitMult;
		logic [1:0] refPerChar;
		speed_range_t range;
		logic [10:0] baudMin;
		logic [10:0] baudMax;
		logic [7:0] refMinMhz;
		logic [7:0] refMaxMhz;
	} rate_t;

endpackage

// File: enable_latch.sv
// transparent-while-high enable latch modelled as a register
module enable_latch #(
	parameter logic [7:0] RESET_VALUE = 8'hff
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe,
	input wire logic [7:0] busIn,
	output logic [7:0] value
);

	typedef struct packed {
		logic [7:0] held;
	} latch_state_t;

	latch_state_t state;
	latch_state_t next_state;

	// load on every character clock while open, hold once closed
	always_comb begin
		next_state = state;
		if (strobe) begin
			next_state.held = busIn; // R19 R10
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state.held <= RESET_VALUE;
		end else begin
			state <= next_state;
		end
	end

	// open latch passes the bus straight through
	assign value = strobe ? busIn : state.held; // R7
endmodule

// File: word_sync_gen.sv
// atomic sixteen-character word sync sequencer for one channel
module word_sync_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic active,
	output logic [3:0] index
);

	typedef struct packed {
		logic active;
		logic [3:0] count;
	} sync_state_t;

	sync_state_t state;
	sync_state_t next_state;

	// starts are ignored while a sequence runs, so it cannot be cut short
	always_comb begin
		next_state = state;
		if (state.active) begin
			if (state.count == quad_tx_pkg::SYNC_LAST) begin
				next_state.active = 1'b0;
			end else begin
				next_state.count = state.count + 4'h1;
			end
		end else if (start) begin
			next_state.active = 1'b1;
			next_state.count = 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign active = state.active;
	assign index = state.count;
endmodule

// File: quad_tx_ctrl.sv
// transmit character control, serial driver enables and rate control of a four-channel transceiver
//
// Contract
// R1 - quad bonded, B low 0: A bits give data, fill, special or sync on A
// R2 - quad bonded: channel B type from A low bit and B high bit
// R3 - quad bonded: channel C type from A low bit and C high bit
// R4 - quad bonded: channel D type from A low bit and D high bit
// R5 - quad bonded: B low bit 1 starts 16-character sync on all four channels
// R6 - loopback makes every enabled driver send a static differential one
// R7 - output strobe high passes enable bus straight to the drivers
// R8 - output strobe high with bit low disables driver into minimum power
// R9 - both outputs of a channel off puts its transmit logic in low power
// R10 - falling output strobe captures the bus and holds it until strobe rises
// R11 - odd bits drive second outputs, even bits first outputs, D down to A
// R12 - self-test strobe: odd bits transmit, even receive; receive strobe: even bits only
// R13 - host allows up to 10ms settling after re-enabling a fully disabled channel
// R14 - bit clock is reference times 10 or 20 by multiplier select; character clock supplied
// R15 - speed select low, middle, high gives 200-400, 400-800, 800-1500 MBaud
// R16 - host keeps reference in range; half range when multiplier select is 1
// R17 - bonding mode bit high treats four channels as one bonded path
// R18 - quad bonded: low control bits of channels C and D are ignored
// R19 - each enable latch loads the bus every clock while its strobe is high
module quad_tx_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] chanACharCtrl,
	input wire logic [1:0] chanBCharCtrl,
	input wire logic [1:0] chanCCharCtrl,
	input wire logic [1:0] chanDCharCtrl,
	input wire logic [3:0][7:0] txData,
	output quad_tx_pkg::tx_out_t txOut,
	output quad_tx_pkg::driver_ctl_t serialOutDriver,
	output quad_tx_pkg::chan_enable_t chanEnable,
	output quad_tx_pkg::rate_t rate
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic quadBond;
		logic loopback;
		logic multSel;
		logic [1:0] speedSel;
		logic [7:0] sharedEnableBus;
		logic oeStrobe;
		logic bistStrobe;
		logic rxStrobe;
		logic [31:0] readData;
		quad_tx_pkg::char_kind_t [3:0] kind;
		logic [3:0][7:0] data;
		logic [3:0] bistOn;
		quad_tx_pkg::driver_ctl_t drv;
		quad_tx_pkg::chan_enable_t chan;
		quad_tx_pkg::rate_t rate;
	} ctrl_state_t;

	ctrl_state_t state;
	ctrl_state_t next_state;

	// latched enable values, one per strobe
	logic [7:0] oeValue;
	logic [7:0] bistValue;
	logic [7:0] rxValue;
	logic [3:0] syncStart;
	logic [3:0] syncActive;
	logic [3:0][3:0] syncIndex;

	// ****************************************
	// helpers
	// ****************************************

	// two control bits to a character kind, shared by every channel
	function automatic quad_tx_pkg::char_kind_t charKindOf(input logic [1:0] bits);
		quad_tx_pkg::char_kind_t k;
		case (bits)
			2'h0: k = quad_tx_pkg::CHAR_DATA;
			2'h1: k = quad_tx_pkg::CHAR_FILL;
			2'h2: k = quad_tx_pkg::CHAR_SPECIAL;
			default: k = quad_tx_pkg::CHAR_SYNC;
		endcase
		return k;
	endfunction

	// mapped address check, used only for the error answer
	function automatic logic regHit(input logic [7:0] addr);
		logic hit;
		if (addr == quad_tx_pkg::CTRL_OFFSET) begin
			hit = 1'b1;
		end else if (addr == quad_tx_pkg::ENABLE_OFFSET) begin
			hit = 1'b1;
		end else if (addr == quad_tx_pkg::STATUS_OFFSET) begin
			hit = 1'b1;
		end else if (addr == quad_tx_pkg::RATE_OFFSET) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
		return hit;
	endfunction

	// ****************************************
	// enable latches
	// ****************************************
	// output enable latch, every driver on after reset
	enable_latch #(
		.RESET_VALUE(quad_tx_pkg::OE_LATCH_RESET)
	) oeLatch (
		.clk(clk),
		.rst_n(rst_n),
		.strobe(state.oeStrobe),
		.busIn(state.sharedEnableBus),
		.value(oeValue)
	);

	// self-test latch, bits active low so reset leaves tests off
	enable_latch #(
		.RESET_VALUE(quad_tx_pkg::BIST_LATCH_RESET)
	) bistLatch (
		.clk(clk),
		.rst_n(rst_n),
		.strobe(state.bistStrobe),
		.busIn(state.sharedEnableBus),
		.value(bistValue)
	);

	// receive enable latch, odd bits unused
	enable_latch #(
		.RESET_VALUE(quad_tx_pkg::RX_LATCH_RESET)
	) rxLatch (
		.clk(clk),
		.rst_n(rst_n),
		.strobe(state.rxStrobe),
		.busIn(state.sharedEnableBus),
		.value(rxValue)
	);

	// ****************************************
	// word sync sequencers
	// ****************************************
	// one sequencer per channel keeps bonded starts aligned
	generate
		for (genvar ch = 0; ch < 4; ch++) begin : gSync
			word_sync_gen syncGen (
				.clk(clk),
				.rst_n(rst_n),
				.start(syncStart[ch]),
				.active(syncActive[ch]),
				.index(syncIndex[ch])
			);
		end
	endgenerate

	// ****************************************
	// character decode
	// ****************************************

	// choose each channel's character kind and whether it starts a sync run
	always_comb begin
		quad_tx_pkg::char_kind_t [3:0] kindNow;
		logic [3:0] bistNow;
		logic [3:0][1:0] ctrlBits;
		bistNow = '0;
		ctrlBits = {chanDCharCtrl, chanCCharCtrl, chanBCharCtrl, chanACharCtrl};
		syncStart = '0;
		// self-test flags per channel, kinds default to data
		for (int ch = 0; ch < 4; ch++) begin
			kindNow[ch] = quad_tx_pkg::CHAR_DATA;
			bistNow[ch] = ~bistValue[2 * ch + 1]; // R12
		end
		// bonded: the channel A low bit qualifies every channel
		if (state.quadBond) begin // R17
			kindNow[0] = charKindOf(chanACharCtrl); // R1
			kindNow[1] = charKindOf({chanBCharCtrl[1], chanACharCtrl[0]}); // R2
			kindNow[2] = charKindOf({chanCCharCtrl[1], chanACharCtrl[0]}); // R3 R18
			kindNow[3] = charKindOf({chanDCharCtrl[1], chanACharCtrl[0]}); // R4 R18
			if (chanBCharCtrl[0]) begin
				for (int ch = 0; ch < 4; ch++) begin
					kindNow[ch] = quad_tx_pkg::CHAR_SYNC; // R5
				end
			end
		end else begin
			// non-bonded: each channel reads its own two bits
			for (int ch = 0; ch < 4; ch++) begin
				kindNow[ch] = charKindOf(ctrlBits[ch]);
			end
		end
		// self-test wins, then a sync kind starts that channel's sequencer
		for (int ch = 0; ch < 4; ch++) begin
			if (bistNow[ch]) begin
				kindNow[ch] = quad_tx_pkg::CHAR_DATA; // self-test ignores the host control bits
			end
			syncStart[ch] = (kindNow[ch] == quad_tx_pkg::CHAR_SYNC); // R5
		end
		// kind, self-test flags and data are held for one character
		next_state = state;
		next_state.kind = kindNow;
		next_state.bistOn = bistNow;
		next_state.data = txData;

		// driver enables, loopback forcing and channel power
		next_state.drv.enable = oeValue; // R7 R11
		next_state.drv.minPower = ~oeValue; // R8
		next_state.drv.forceOne = oeValue & {8{state.loopback}}; // R6
		for (int ch = 0; ch < 4; ch++) begin
			next_state.drv.chanLowPower[ch] = ~oeValue[2 * ch] & ~oeValue[2 * ch + 1]; // R9
			next_state.chan.txBist[ch] = ~bistValue[2 * ch + 1]; // R12
			next_state.chan.rxBist[ch] = ~bistValue[2 * ch]; // R12
			next_state.chan.rxEnable[ch] = rxValue[2 * ch]; // R12
		end

		// multiplier and speed range
		next_state.rate.bitMult = state.multSel ? quad_tx_pkg::MULT_HALF : quad_tx_pkg::MULT_FULL; // R14
		next_state.rate.refPerChar = state.multSel ? 2'h2 : 2'h1; // R14
		// the open level 2'h3 falls back to the middle range
		case (state.speedSel)
			2'h0: begin
				next_state.rate.range = quad_tx_pkg::SPEED_LOW; // R15
				next_state.rate.baudMin = quad_tx_pkg::BAUD_LOW_MIN;
				next_state.rate.baudMax = quad_tx_pkg::BAUD_LOW_MAX;
				next_state.rate.refMinMhz = quad_tx_pkg::REF_LOW_MIN;
				next_state.rate.refMaxMhz = quad_tx_pkg::REF_LOW_MAX;
			end
			2'h2: begin
				next_state.rate.range = quad_tx_pkg::SPEED_HIGH; // R15
				next_state.rate.baudMin = quad_tx_pkg::BAUD_HIGH_MIN;
				next_state.rate.baudMax = quad_tx_pkg::BAUD_HIGH_MAX;
				next_state.rate.refMinMhz = quad_tx_pkg::REF_HIGH_MIN;
				next_state.rate.refMaxMhz = quad_tx_pkg::REF_HIGH_MAX;
			end
			default: begin
				next_state.rate.range = quad_tx_pkg::SPEED_MID; // R15
				next_state.rate.baudMin = quad_tx_pkg::BAUD_MID_MIN;
				next_state.rate.baudMax = quad_tx_pkg::BAUD_MID_MAX;
				next_state.rate.refMinMhz = quad_tx_pkg::REF_MID_MIN;
				next_state.rate.refMaxMhz = quad_tx_pkg::REF_MID_MAX;
			end
		endcase
		if (state.multSel) begin
			next_state.rate.refMinMhz = next_state.rate.refMinMhz >> 1; // R16
			next_state.rate.refMaxMhz = next_state.rate.refMaxMhz >> 1; // R16
		end

		// apb write at the access phase
		if (psel && penable && pwrite) begin
			if (paddr == quad_tx_pkg::CTRL_OFFSET) begin
				next_state.quadBond = pwdata[quad_tx_pkg::CTRL_QUAD_BIT];
				next_state.loopback = pwdata[quad_tx_pkg::CTRL_LOOP_BIT];
				next_state.multSel = pwdata[quad_tx_pkg::CTRL_MULT_BIT];
				next_state.speedSel = pwdata[quad_tx_pkg::CTRL_SPEED_LSB +: 2];
			end else if (paddr == quad_tx_pkg::ENABLE_OFFSET) begin
				next_state.sharedEnableBus = pwdata[quad_tx_pkg::ENABLE_BUS_LSB +: 8];
				next_state.oeStrobe = pwdata[quad_tx_pkg::ENABLE_OE_BIT];
				next_state.bistStrobe = pwdata[quad_tx_pkg::ENABLE_BIST_BIT];
				next_state.rxStrobe = pwdata[quad_tx_pkg::ENABLE_RX_BIT];
			end
		end

		// apb read data captured in the setup phase
		if (psel && !penable) begin
			next_state.readData = '0;
			if (paddr == quad_tx_pkg::CTRL_OFFSET) begin
				next_state.readData[quad_tx_pkg::CTRL_QUAD_BIT] = state.quadBond;
				next_state.readData[quad_tx_pkg::CTRL_LOOP_BIT] = state.loopback;
				next_state.readData[quad_tx_pkg::CTRL_MULT_BIT] = state.multSel;
				next_state.readData[quad_tx_pkg::CTRL_SPEED_LSB +: 2] = state.speedSel;
			end else if (paddr == quad_tx_pkg::ENABLE_OFFSET) begin
				next_state.readData[quad_tx_pkg::ENABLE_BUS_LSB +: 8] = state.sharedEnableBus;
				next_state.readData[quad_tx_pkg::ENABLE_OE_BIT] = state.oeStrobe;
				next_state.readData[quad_tx_pkg::ENABLE_BIST_BIT] = state.bistStrobe;
				next_state.readData[quad_tx_pkg::ENABLE_RX_BIT] = state.rxStrobe;
			end else if (paddr == quad_tx_pkg::STATUS_OFFSET) begin
				next_state.readData[quad_tx_pkg::STATUS_DRV_LSB +: 8] = state.drv.enable;
				next_state.readData[quad_tx_pkg::STATUS_LOWPWR_LSB +: 4] = state.drv.chanLowPower;
				next_state.readData[quad_tx_pkg::STATUS_TXBIST_LSB +: 4] = state.chan.txBist;
				next_state.readData[quad_tx_pkg::STATUS_RXBIST_LSB +: 4] = state.chan.rxBist;
				next_state.readData[quad_tx_pkg::STATUS_RXEN_LSB +: 4] = state.chan.rxEnable;
				next_state.readData[quad_tx_pkg::STATUS_SYNC_LSB +: 4] = syncActive;
			end else if (paddr == quad_tx_pkg::RATE_OFFSET) begin
				next_state.readData[quad_tx_pkg::RATE_REFMIN_LSB +: 8] = state.rate.refMinMhz;
				next_state.readData[quad_tx_pkg::RATE_REFMAX_LSB +: 8] = state.rate.refMaxMhz;
				next_state.readData[quad_tx_pkg::RATE_MULT_LSB +: 5] = state.rate.bitMult;
				next_state.readData[quad_tx_pkg::RATE_RANGE_LSB +: 2] = state.rate.range;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	// reset leaves drivers and receivers on and the slowest range chosen
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= '0;
			{state.quadBond, state.loopback, state.multSel, state.speedSel} <= quad_tx_pkg::CTRL_RESET;
			{state.rxStrobe, state.bistStrobe, state.oeStrobe, state.sharedEnableBus} <= quad_tx_pkg::ENABLE_RESET;
			state.drv.enable <= quad_tx_pkg::OE_LATCH_RESET;
			state.drv.minPower <= ~quad_tx_pkg::OE_LATCH_RESET;
			state.chan.rxEnable <= 4'hf;
			state.rate.bitMult <= quad_tx_pkg::MULT_FULL;
			state.rate.refPerChar <= 2'h1;
			state.rate.range <= quad_tx_pkg::SPEED_LOW;
			state.rate.baudMin <= quad_tx_pkg::BAUD_LOW_MIN;
			state.rate.baudMax <= quad_tx_pkg::BAUD_LOW_MAX;
			state.rate.refMinMhz <= quad_tx_pkg::REF_LOW_MIN;
			state.rate.refMaxMhz <= quad_tx_pkg::REF_LOW_MAX;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	// a running sync run overrides the decoded kind on its channel
	always_comb begin
		txOut.data = state.data;
		txOut.bistOn = state.bistOn;
		txOut.syncActive = syncActive;
		txOut.syncIndex = syncIndex;
		for (int ch = 0; ch < 4; ch++) begin
			txOut.kind[ch] = syncActive[ch] ? quad_tx_pkg::CHAR_SYNC : state.kind[ch]; // R5
		end
	end

	// driver, channel and rate outputs straight from their flip-flops
	assign serialOutDriver = state.drv;
	assign chanEnable = state.chan;
	assign rate = state.rate;

	// zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !regHit(paddr);
	assign prdata = state.readData;
endmodule

// File: host_char_model.sv
// host-side model that drives the parallel character interface
module host_char_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] ctrlReq,
	input wire logic [31:0] dataReq,
	output logic [1:0] chanACharCtrl,
	output logic [1:0] chanBCharCtrl,
	output logic [1:0] chanCCharCtrl,
	output logic [1:0] chanDCharCtrl,
	output logic [3:0][7:0] txData
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// one-deep host output register
	// ****************************************
	// reference clock assumed in range, no traffic relied on right after a channel wakes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{chanDCharCtrl, chanCCharCtrl, chanBCharCtrl, chanACharCtrl} <= 8'h00;
			txData <= 32'h00000000;
		end else begin
			{chanDCharCtrl, chanCCharCtrl, chanBCharCtrl, chanACharCtrl} <= ctrlReq;
			txData <= dataReq;
		end
	end
endmodule

// File: quad_tx_ctrl_sva.sv
// assertion checker of the quad transmit control block
module quad_tx_ctrl_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [3:0][7:0] txData,
	input wire quad_tx_pkg::tx_out_t txOut,
	input wire quad_tx_pkg::driver_ctl_t serialOutDriver,
	input wire quad_tx_pkg::rate_t rate
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ****************************************
	// register write strobes
	// ****************************************
	logic enWr;
	logic ctrlWr;
	assign enWr = psel && penable && pwrite && (paddr == quad_tx_pkg::ENABLE_OFFSET);
	assign ctrlWr = psel && penable && pwrite && (paddr == quad_tx_pkg::CTRL_OFFSET);

	// ****************************************
	// word sync run
	// ****************************************
	sequence s_sync_begin(int ch);
		txOut.syncActive[ch] && txOut.syncIndex[ch] == 4'h0;
	endsequence
	sequence s_sync_end(int ch);
		txOut.syncActive[ch] && txOut.syncIndex[ch] == 4'hf;
	endsequence
	property p_sync_run(int ch);
		$rose(txOut.syncActive[ch]) |-> s_sync_begin(ch) ##15 s_sync_end(ch);
	endproperty
	property p_sync_kind(int ch);
		txOut.syncActive[ch] |-> txOut.kind[ch] == quad_tx_pkg::CHAR_SYNC;
	endproperty
	for (genvar g = 0; g < 4; g++) begin : g_sync
		a_sync_run: assert property (p_sync_run(g)) else $error("sync run not sixteen characters");
		a_sync_kind: assert property (p_sync_kind(g)) else $error("sync active without sync kind");
	end

	// ****************************************
	// drivers and rate
	// ****************************************
	property p_min_power;
		serialOutDriver.minPower == ~serialOutDriver.enable;
	endproperty
	a_min_power: assert property (p_min_power) else $error("min power not inverse of enable");
	property p_low_power;
		serialOutDriver.chanLowPower == {~|serialOutDriver.enable[7:6], ~|serialOutDriver.enable[5:4],
			~|serialOutDriver.enable[3:2], ~|serialOutDriver.enable[1:0]};
	endproperty
	a_low_power: assert property (p_low_power) else $error("channel low power wrong");
	property p_force;
		(serialOutDriver.forceOne & ~serialOutDriver.enable) == 8'h00;
	endproperty
	a_force: assert property (p_force) else $error("forced one on disabled driver");
	property p_hold;
		$past(rst_n) && !$past(enWr, 2) |-> $stable(serialOutDriver.enable);
	endproperty
	a_hold: assert property (p_hold) else $error("driver enables moved without write");
	property p_rate_hold;
		$past(rst_n) && !$past(ctrlWr, 2) |-> $stable(rate);
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate moved without write");
	property p_mult;
		(rate.bitMult == 5'h14 && rate.refPerChar == 2'h2) || (rate.bitMult == 5'h0a && rate.refPerChar == 2'h1);
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier pair wrong");
	property p_baud;
		(rate.range == quad_tx_pkg::SPEED_LOW && rate.baudMin == 11'h0c8 && rate.baudMax == 11'h190) ||
		(rate.range == quad_tx_pkg::SPEED_MID && rate.baudMin == 11'h190 && rate.baudMax == 11'h320) ||
		(rate.range == quad_tx_pkg::SPEED_HIGH && rate.baudMin == 11'h320 && rate.baudMax == 11'h5dc);
	endproperty
	a_baud: assert property (p_baud) else $error("baud range wrong");
	property p_data_pipe;
		$past(rst_n) |-> txOut.data == $past(txData);
	endproperty
	a_data_pipe: assert property (p_data_pipe) else $error("data not one character late");
endmodule

bind quad_tx_ctrl quad_tx_ctrl_sva i_sva (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .txData, .txOut,
	.serialOutDriver, .rate);

// File: tb.sv
// self-checking testbench of the quad transmit control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] chanACharCtrl, chanBCharCtrl, chanCCharCtrl, chanDCharCtrl;
	logic [3:0][7:0] txData;
	logic [7:0] ctrlReq = 8'h00;
	logic [31:0] dataReq = 32'h00000000;
	quad_tx_pkg::tx_out_t txOut;
	quad_tx_pkg::driver_ctl_t serialOutDriver;
	quad_tx_pkg::chan_enable_t chanEnable;
	quad_tx_pkg::rate_t rate;
	int bad_count = 0;
	int n_compared = 0;
	logic [7:0] refLo [3] = '{8'h14, 8'h28, 8'h50};
	logic [7:0] refHi [3] = '{8'h28, 8'h50, 8'h96};
	logic [10:0] baudLo [3] = '{11'h0c8, 11'h190, 11'h320};
	logic [10:0] baudHi [3] = '{11'h190, 11'h320, 11'h5dc};

	// clock of 25 ns
	always #12.5 clk = ~clk;

	host_char_model i_host (.clk, .rst_n, .ctrlReq, .dataReq, .chanACharCtrl, .chanBCharCtrl, .chanCCharCtrl,
		.chanDCharCtrl, .txData);
	quad_tx_ctrl i_dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.chanACharCtrl, .chanBCharCtrl, .chanCCharCtrl, .chanDCharCtrl, .txData, .txOut, .serialOutDriver,
		.chanEnable, .rate);

	// ****************************************
	// compare, report and bus tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			tally_and_finish();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		check(r, exp);
		check({31'h00000000, e}, {31'h00000000, expErr});
	endtask
	task automatic settle();
		@(posedge clk);
		@(negedge clk);
	endtask
	// one-cycle control pulse, kinds checked half a character after the device samples it
	task automatic send(input logic [7:0] c, input logic [31:0] d, input logic [7:0] expKind);
		@(posedge clk);
		ctrlReq <= c;
		dataReq <= d;
		@(posedge clk);
		ctrlReq <= 8'h00;
		settle();
		check(32'(txOut.kind), {24'h000000, expKind});
		check(txOut.data, d);
		repeat (20) @(posedge clk);
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [1:0] r;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_check(quad_tx_pkg::ENABLE_OFFSET, 32'h000000ff, 1'b0);
		rd_check(quad_tx_pkg::STATUS_OFFSET, 32'h00f000ff, 1'b0);
		rd_check(8'h10, 32'h00000000, 1'b1);
		for (int s = 0; s < 4; s++) begin
			for (int m = 0; m < 2; m++) begin
				r = (s == 2) ? 2'h2 : ((s == 0) ? 2'h0 : 2'h1);
				wr(quad_tx_pkg::CTRL_OFFSET, 32'(s * 8 + m * 4));
				rd_check(quad_tx_pkg::RATE_OFFSET, {9'h000, r, (m ? 5'h14 : 5'h0a), refHi[r] >> m, refLo[r] >> m},
					1'b0);
				check(32'({rate.baudMax, rate.baudMin}), 32'({baudHi[r], baudLo[r]}));
			end
		end
		wr(quad_tx_pkg::CTRL_OFFSET, 32'h00000000);
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h0000013c);
		settle();
		check(32'(serialOutDriver), 32'({8'h3c, 8'h00, 8'hc3, 4'h9}));
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h000000ff);
		rd_check(quad_tx_pkg::STATUS_OFFSET, 32'h00f0093c, 1'b0);
		wr(quad_tx_pkg::CTRL_OFFSET, 32'h00000002);
		settle();
		check(32'(serialOutDriver.forceOne), 32'h0000003c);
		wr(quad_tx_pkg::CTRL_OFFSET, 32'h00000000);
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h000001ff);
		settle();
		check(32'(serialOutDriver), 32'({8'hff, 8'h00, 8'h00, 4'h0}));
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h00000296);
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h000000ff);
		rd_check(quad_tx_pkg::STATUS_OFFSET, 32'h00f960ff, 1'b0);
		check(32'(txOut.bistOn), 32'h00000006);
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h000004aa);
		settle();
		check(32'(chanEnable), 32'h00000690);
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h00000455);
		settle();
		check(32'(chanEnable), 32'h0000069f);
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h000006ff);
		wr(quad_tx_pkg::ENABLE_OFFSET, 32'h000000ff);
		settle();
		check(32'(chanEnable), 32'h0000000f);
		send(8'hc9, 32'h11223344, 8'hc9);
		wr(quad_tx_pkg::CTRL_OFFSET, 32'h00000001);
		for (int i = 0; i < 32; i++) begin
			send({i[4], 1'b1, i[3], 1'b1, i[2], 1'b0, i[0], i[1]}, 32'(i * 32'h01010101),
				{i[4], i[1], i[3], i[1], i[2], i[1], i[0], i[1]});
		end
		send(8'h94, 32'ha5a55a5a, 8'hff);
		tally_and_finish();
	end
endmodule
